// file: src/hpd_pkg.sv
// constants for the host-to-pci outbound address decoder
// assumes a 34-bit host address and a 32-bit pci address/data bus
package hpd_pkg;
    localparam int HADR_W = 34;
    // region select on host address bits 33:28
    localparam logic [5:0] RGN_CSR   = 6'h1a;
    localparam logic [5:0] RGN_IACK  = 6'h1b;
    localparam logic [4:0] RGN_IO    = 5'h0e;  // bits 33:29
    localparam logic [4:0] RGN_CFG   = 5'h0f;  // bits 33:29
    // pci bus commands
    localparam logic [3:0] CMD_IACK  = 4'h0;
    localparam logic [3:0] CMD_SPEC  = 4'h1;
    localparam logic [3:0] CMD_IORD  = 4'h2;
    localparam logic [3:0] CMD_IOWR  = 4'h3;
    localparam logic [3:0] CMD_CFGRD = 4'ha;
    localparam logic [3:0] CMD_CFGWR = 4'hb;
    // low-active byte enables
    localparam logic [3:0] BE_NONE   = 4'hf;
    localparam logic [3:0] BE_ALL    = 4'h0;
    localparam logic [3:0] BE_B0     = 4'he;
    localparam logic [3:0] BE_B1     = 4'hd;
    localparam logic [3:0] BE_B2     = 4'hb;
    localparam logic [3:0] BE_B3     = 4'h7;
    localparam logic [3:0] BE_W0     = 4'hc;
    localparam logic [3:0] BE_W1     = 4'h9;
    localparam logic [3:0] BE_W2     = 4'h3;
    localparam logic [3:0] BE_T0     = 4'h8;
    localparam logic [3:0] BE_T1     = 4'h1;
    // size codes on host bits 4:3
    localparam logic [1:0] SZ_BYTE   = 2'h0;
    localparam logic [1:0] SZ_WORD   = 2'h1;
    localparam logic [1:0] SZ_TRI    = 2'h2;
    localparam logic [1:0] SZ_LONG   = 2'h3;
    localparam logic [4:0] DEV_LIMIT = 5'h15;
    localparam logic [7:0] XTN_ZERO  = 8'h00;
    localparam logic [1:0] BUS_PRI   = 2'h0;
    localparam logic [1:0] BUS_SEC   = 2'h1;
    localparam logic [31:0] AD_ZERO  = 32'h0000_0000;
    localparam logic [20:0] IDSEL_ONE = 21'h00_0001;
endpackage

// file: src/hpd_decode.sv
// host_to_pci_io_config_decode: decodes one host bus access per request
// into pci address, command, byte enables and data-phase count
// assumes requests are single-cycle pulses from logic on clock_i
`timescale 1ns/10ps
// Contract
// [R1] sparse io region reads/writes give io commands
// [R2] host bits 28:8 go to ad 23:3
// [R3] ad 31:24 zero or extension register
// [R4] byte and word enables, ad 2:0 mapping
// [R5] tribyte, longword, quadword enables and address
// [R6] illegal size codes still complete
// [R7] byte enables are active low
// [R8] software avoids sparse io quadwords
// [R9] bridge register region always claimed
// [R10] iack region reads give interrupt acknowledge
// [R11] iack region writes give special cycle
// [R12] software uses longword stores there
// [R13] config region gives config read/write
// [R14] config ad 1:0 from extension register
// [R15] function and register select from host bits
// [R16] primary bus one-hot device select
// [R17] secondary bus number and device fields
// [R18] config byte masks as sparse io
// [R19] primary target needs ad 1:0 zero
// [R20] pci bridges forward or reissue config
// [R21] host bits 4:3 from longword mask
// [R22] small accesses use one data phase
module hpd_decode
    import hpd_pkg::*;
(
    input  wire logic              clock_i,
    input  wire logic              srst_i,
    input  wire logic              req_i,
    input  wire logic              write_i,
    input  wire logic [HADR_W-1:0] host_bus_address_i,
    input  wire logic [7:0]        host_longword_write_mask_i,
    input  wire logic [7:0]        io_config_addr_extension_reg_i,
    output logic                   pci_req_o,
    output logic                   csr_claim_o,
    output logic                   miss_o,
    output logic [31:0]            pci_ad_o,
    output logic [3:0]             pci_cmd_o,
    output logic [3:0]             pci_be_n_o,
    output logic [1:0]             pci_phases_o
);
    logic [1:0]  size_w;
    logic [1:0]  lane_w;
    logic        qw_w;
    logic [3:0]  be_w;
    logic [2:0]  alo_w;
    logic        is_io;
    logic        is_cfg;
    logic        is_csr;
    logic        is_iack;
    logic [7:0]  fixed_zero_addr_extension;
    logic [20:0] idsel_w;
    logic [4:0]  dev_w;

    assign fixed_zero_addr_extension = XTN_ZERO;
    assign lane_w = host_bus_address_i[6:5];
    assign dev_w  = host_bus_address_i[20:16];

    // derive host bits 4:3 from the longword mask
    always_comb
    begin
        size_w = host_longword_write_mask_i[1:0];      // [R21]
        if (write_i)
        begin
            if (host_longword_write_mask_i[1:0] != 2'h0)
                size_w = SZ_BYTE;                      // [R21]
            else if (host_longword_write_mask_i[3:2] != 2'h0)
                size_w = SZ_WORD;
            else if (host_longword_write_mask_i[5:4] != 2'h0)
                size_w = SZ_TRI;
            else
                size_w = SZ_LONG;
        end
    end

    assign qw_w = (size_w == SZ_LONG) && (lane_w == 2'h3);

    // byte enable and low address generation, active low
    always_comb
    begin
        be_w  = BE_ALL;                                // [R6]
        alo_w = {host_bus_address_i[7], lane_w};       // [R4]
        unique case (size_w)
            SZ_BYTE:
            begin
                unique case (lane_w)                   // [R7]
                    2'h0: be_w = BE_B0;
                    2'h1: be_w = BE_B1;
                    2'h2: be_w = BE_B2;
                    2'h3: be_w = BE_B3;
                endcase
            end
            SZ_WORD:
            begin
                if (lane_w == 2'h0)
                    be_w = BE_W0;                      // [R4]
                else if (lane_w == 2'h1)
                    be_w = BE_W1;
                else if (lane_w == 2'h2)
                    be_w = BE_W2;
            end
            SZ_TRI:
            begin
                if (lane_w == 2'h0)
                    be_w = BE_T0;                      // [R5]
                else if (lane_w == 2'h1)
                    be_w = BE_T1;
            end
            SZ_LONG:
            begin
                be_w = BE_ALL;                         // [R5]
                if (qw_w)
                    alo_w = 3'h0;                      // [R5]
            end
        endcase
    end

    // one-hot device select for primary bus
    always_comb
    begin
        idsel_w = 21'h00_0000;
        if (dev_w < DEV_LIMIT)
            idsel_w = IDSEL_ONE << dev_w;              // [R16]
    end

    assign is_io   = host_bus_address_i[33:29] == RGN_IO;
    assign is_cfg  = host_bus_address_i[33:29] == RGN_CFG;
    assign is_csr  = host_bus_address_i[33:28] == RGN_CSR;
    assign is_iack = host_bus_address_i[33:28] == RGN_IACK;

    // request strobe and claim flags
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            pci_req_o   <= 1'b0;
            csr_claim_o <= 1'b0;
            miss_o      <= 1'b0;
        end
        else
        begin
            pci_req_o   <= req_i && (is_io || is_cfg || is_iack); // [R6]
            csr_claim_o <= req_i && is_csr;                       // [R9]
            miss_o      <= req_i && !(is_io || is_cfg || is_iack
                                      || is_csr);
        end
    end

    // address, command, enables and phase count
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            pci_ad_o     <= AD_ZERO;
            pci_cmd_o    <= CMD_IORD;
            pci_be_n_o   <= BE_NONE;
            pci_phases_o <= 2'h0;
        end
        else if (req_i && is_io)
        begin
            pci_cmd_o  <= write_i ? CMD_IOWR : CMD_IORD;           // [R1]
            pci_ad_o   <= {(host_bus_address_i[28:23] == 6'h00)
                           ? fixed_zero_addr_extension
                           : io_config_addr_extension_reg_i,       // [R3]
                           host_bus_address_i[28:8],               // [R2]
                           alo_w};
            pci_be_n_o <= be_w;                                    // [R4]
            pci_phases_o <= qw_w ? 2'h2 : 2'h1;                    // [R22]
        end
        else if (req_i && is_iack)
        begin
            pci_cmd_o    <= write_i ? CMD_SPEC : CMD_IACK;  // [R10] [R11]
            pci_ad_o     <= AD_ZERO;
            pci_be_n_o   <= write_i ? BE_ALL : be_w;               // [R10]
            pci_phases_o <= qw_w ? 2'h2 : 2'h1;                    // [R22]
        end
        else if (req_i && is_cfg)
        begin
            pci_cmd_o  <= write_i ? CMD_CFGWR : CMD_CFGRD;         // [R13]
            pci_be_n_o <= be_w;                                    // [R18]
            pci_phases_o <= qw_w ? 2'h2 : 2'h1;                    // [R22]
            if (io_config_addr_extension_reg_i[1:0] == BUS_PRI)
                pci_ad_o <= {idsel_w,                        // [R16] [R19]
                             host_bus_address_i[15:13],
                             host_bus_address_i[12:7],
                             io_config_addr_extension_reg_i[1:0]}; // [R14]
            else
                pci_ad_o <= {8'h00,                                // [R17]
                             host_bus_address_i[28:21],
                             dev_w,                          // [R17] [R20]
                             host_bus_address_i[15:13],            // [R15]
                             host_bus_address_i[12:7],
                             io_config_addr_extension_reg_i[1:0]}; // [R14]
        end
    end

    // spot checks across io, register, iack and config decode
    iocmd_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_io && write_i |=> pci_req_o && pci_cmd_o == CMD_IOWR)
        else $error("io write command wrong"); // [R1]
    iohi_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_io && host_bus_address_i[28:23] == 6'h00
        |=> pci_ad_o[31:24] == 8'h00)
        else $error("low io extension not zero"); // [R3]
    ioadr_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_io |=>
        pci_ad_o[23:3] == $past(host_bus_address_i[28:8]))
        else $error("io address bits wrong"); // [R2]
    bytebe_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_io && size_w == SZ_BYTE |=>
        $countones(pci_be_n_o) == 3)
        else $error("byte enable not one lane"); // [R4]
    csrclm_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_csr |=> csr_claim_o && !pci_req_o)
        else $error("register access not claimed"); // [R9]
    iackcmd_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_iack |=>
        pci_cmd_o == ($past(write_i) ? CMD_SPEC : CMD_IACK))
        else $error("iack region command wrong"); // [R10]
    cfgbus_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_cfg |=>
        pci_ad_o[1:0] == $past(io_config_addr_extension_reg_i[1:0]))
        else $error("config bus select wrong"); // [R14]
    cfgone_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_cfg && io_config_addr_extension_reg_i[1:0] == BUS_PRI
        |=> $countones(pci_ad_o[31:11]) <= 1)
        else $error("device select not one-hot"); // [R16]
    onephs_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && (is_io || is_cfg) && !qw_w |=> pci_phases_o == 2'h1)
        else $error("small access not single phase"); // [R22]

    // io command, extension and low address
    iordcmd_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_io && !write_i |=> pci_req_o && pci_cmd_o == CMD_IORD)
        else $error("io read command wrong"); // [R1]
    ioext_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_io && host_bus_address_i[28:23] != 6'h00
        |=> pci_ad_o[31:24] == $past(io_config_addr_extension_reg_i))
        else $error("io extension not used"); // [R3]
    ioalo_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_io && !qw_w |=>
        pci_ad_o[2:0] == $past(host_bus_address_i[7:5]))
        else $error("io low address wrong"); // [R4]

    // byte enables per size and lane, active low
    bytelane_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_io && size_w == SZ_BYTE |=>
        !pci_be_n_o[$past(lane_w)])
        else $error("byte lane not enabled"); // [R7]
    wordbe_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_io && size_w == SZ_WORD && lane_w == 2'h0
        |=> pci_be_n_o == BE_W0)
        else $error("low word enables wrong"); // [R4]
    wordhi_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_io && size_w == SZ_WORD && lane_w == 2'h2
        |=> pci_be_n_o == BE_W2)
        else $error("high word enables wrong"); // [R4]
    tribe_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_io && size_w == SZ_TRI && lane_w == 2'h1
        |=> pci_be_n_o == BE_T1)
        else $error("upper tribyte enables wrong"); // [R5]
    longbe_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_io && size_w == SZ_LONG && lane_w == 2'h0
        |=> pci_be_n_o == BE_ALL && pci_phases_o == 2'h1)
        else $error("longword enables wrong"); // [R5]
    quadadr_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_io && qw_w |=> pci_ad_o[2:0] == 3'h0
        && pci_be_n_o == BE_ALL && pci_phases_o == 2'h2)
        else $error("quadword access wrong"); // [R5]
    illegal_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && (is_io || is_cfg) && size_w == SZ_TRI && lane_w[1]
        |=> pci_req_o && pci_be_n_o == BE_ALL)
        else $error("illegal size not completed"); // [R6]
    rdsize_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_io && !write_i
        && host_longword_write_mask_i[1:0] == SZ_WORD && lane_w == 2'h1
        |=> pci_be_n_o == BE_W1)
        else $error("read size not from mask"); // [R21]
    wrsize_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_io && write_i && host_longword_write_mask_i == 8'h10
        && lane_w == 2'h0 |=> pci_be_n_o == BE_T0)
        else $error("write size not from mask"); // [R21]

    // iack, special cycle and strobe decode
    iackad_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_iack && !write_i |=> pci_ad_o == AD_ZERO
        && pci_be_n_o == $past(be_w))
        else $error("iack cycle fields wrong"); // [R10]
    specbe_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_iack && write_i |=> pci_cmd_o == CMD_SPEC
        && pci_be_n_o == BE_ALL)
        else $error("special cycle fields wrong"); // [R11]
    miss_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && !(is_io || is_cfg || is_iack || is_csr)
        |=> miss_o && !pci_req_o && !csr_claim_o)
        else $error("unclaimed access not flagged"); // [R9]
    onestb_a: assert property (@(posedge clock_i) disable iff (srst_i)
        $onehot0({pci_req_o, csr_claim_o, miss_o}))
        else $error("more than one strobe"); // [R9]
    idle_a: assert property (@(posedge clock_i) disable iff (srst_i)
        !req_i |=> !pci_req_o && !csr_claim_o && !miss_o)
        else $error("strobe without request"); // [R22]
    hold_a: assert property (@(posedge clock_i) disable iff (srst_i)
        !req_i |=> $stable(pci_ad_o) && $stable(pci_cmd_o)
        && $stable(pci_be_n_o) && $stable(pci_phases_o))
        else $error("address phase not held"); // [R22]

    // configuration command, address fields and byte mask
    cfgcmd_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_cfg |=> pci_req_o
        && pci_cmd_o == ($past(write_i) ? CMD_CFGWR : CMD_CFGRD))
        else $error("config command wrong"); // [R13]
    cfgreg_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_cfg |=>
        pci_ad_o[10:2] == $past(host_bus_address_i[15:7]))
        else $error("function or register wrong"); // [R15]
    cfgsel_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_cfg && io_config_addr_extension_reg_i[1:0] == BUS_PRI
        && dev_w < DEV_LIMIT |=> pci_ad_o[11 + $past(dev_w)]
        && $countones(pci_ad_o[31:11]) == 1)
        else $error("device select line wrong"); // [R16]
    cfgnone_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_cfg && io_config_addr_extension_reg_i[1:0] == BUS_PRI
        && dev_w >= DEV_LIMIT |=> pci_ad_o[31:11] == 21'h00_0000)
        else $error("device select not cleared"); // [R16]
    cfgsec_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_cfg && io_config_addr_extension_reg_i[1:0] != BUS_PRI
        |=> pci_ad_o[31:24] == 8'h00
        && pci_ad_o[23:11] == $past(host_bus_address_i[28:16]))
        else $error("secondary bus fields wrong"); // [R17]
    cfgbe_a: assert property (@(posedge clock_i) disable iff (srst_i)
        req_i && is_cfg && size_w == SZ_BYTE |=>
        !pci_be_n_o[$past(lane_w)] && $countones(pci_be_n_o) == 3)
        else $error("config byte mask wrong"); // [R18]

    c_iord_c: cover property (@(posedge clock_i) req_i && is_io && !write_i);
    c_cfgsec_c: cover property (@(posedge clock_i) req_i && is_cfg
        && io_config_addr_extension_reg_i[1:0] == BUS_SEC);
    c_spec_c: cover property (@(posedge clock_i) req_i && is_iack && write_i);
    c_quad_c: cover property (@(posedge clock_i) req_i && is_io && qw_w);
    c_cfgpri_c: cover property (@(posedge clock_i) req_i && is_cfg
        && io_config_addr_extension_reg_i[1:0] == BUS_PRI);
endmodule // hpd_decode

// file: tb/hpd_pci_partner.sv
// pci-side partner: one primary target and one pci-to-pci bridge
// assumes the decoder's address-phase outputs, valid while pci_req high
`timescale 1ns/10ps
module hpd_pci_partner
    import hpd_pkg::*;
#(
    parameter int         DEV_NUM = 3,
    parameter logic [7:0] SEC_BUS = 8'h05,
    parameter logic [7:0] SUB_BUS = 8'h07
)
(
    input  wire logic        pci_req_i,
    input  wire logic [31:0] pci_ad_i,
    input  wire logic [3:0]  pci_cmd_i,
    output logic             target_accept_o,
    output logic             bridge_reissue_o,
    output logic             bridge_forward_o
);
    logic       cfg_cyc;
    logic [7:0] bus;
    assign bus = pci_ad_i[23:16];
    assign cfg_cyc = pci_req_i
        && (pci_cmd_i == CMD_CFGRD || pci_cmd_i == CMD_CFGWR);
    assign target_accept_o = cfg_cyc && pci_ad_i[11+DEV_NUM]
        && pci_ad_i[1:0] == 2'h0;
    assign bridge_reissue_o = cfg_cyc && pci_ad_i[1:0] == 2'h1
        && bus == SEC_BUS;
    assign bridge_forward_o = cfg_cyc && pci_ad_i[1:0] == 2'h1
        && bus > SEC_BUS && bus <= SUB_BUS;
endmodule // hpd_pci_partner

// file: tb/host_to_pci_io_config_decode_tb_top.sv
// self-checking bench for the outbound host-to-pci decoder
// assumes hpd_pkg, hpd_decode and hpd_pci_partner compiled first
`timescale 1ns/10ps
module host_to_pci_io_config_decode_tb_top
    import hpd_pkg::*;
;
    logic              clock_i = 1'b0;
    logic              srst_i = 1'b1;
    logic              req_i = 1'b0;
    logic              write_i = 1'b0;
    logic [HADR_W-1:0] addr = '0;
    logic [7:0]        mask = 8'h00;
    logic [7:0]        ext = 8'h00;
    logic              pci_req, csr_claim, miss, acc, reiss, fwd;
    logic [31:0]       pci_ad;
    logic [3:0]        pci_cmd, pci_be_n;
    logic [1:0]        pci_phases;
    int                errors = 0;
    int                comparisons = 0;
    logic [HADR_W-1:0] a;

    always #10 clock_i = ~clock_i;

    hpd_decode u_dut (.clock_i(clock_i), .srst_i(srst_i), .req_i(req_i),
        .write_i(write_i), .host_bus_address_i(addr),
        .host_longword_write_mask_i(mask),
        .io_config_addr_extension_reg_i(ext), .pci_req_o(pci_req),
        .csr_claim_o(csr_claim), .miss_o(miss), .pci_ad_o(pci_ad),
        .pci_cmd_o(pci_cmd), .pci_be_n_o(pci_be_n),
        .pci_phases_o(pci_phases));

    hpd_pci_partner u_partner (.pci_req_i(pci_req), .pci_ad_i(pci_ad),
        .pci_cmd_i(pci_cmd), .target_accept_o(acc),
        .bridge_reissue_o(reiss), .bridge_forward_o(fwd));

    task automatic chk(input logic [31:0] got, exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_reset;
        chk({pci_req, csr_claim, miss, pci_be_n}, 7'h0f, "rst flags");
        chk(pci_ad, AD_ZERO, "rst ad");
        chk({pci_cmd, pci_phases}, {CMD_IORD, 2'h0}, "rst cmd");
    endtask

    function automatic logic [1:0] size_of(logic wr, logic [7:0] m);
        if (!wr) return m[1:0];
        if (m[1:0] != 2'h0) return SZ_BYTE;
        if (m[3:2] != 2'h0) return SZ_WORD;
        if (m[5:4] != 2'h0) return SZ_TRI;
        return SZ_LONG;
    endfunction

    task automatic access(input logic [HADR_W-1:0] ha, input logic wr,
                          input logic [7:0] m);
        logic [1:0]  s;
        logic [3:0]  be, cmd;
        logic [31:0] ad;
        logic        io, cf, ia, cs, quad;
        @(posedge clock_i);
        #1;
        req_i = 1'b1;
        write_i = wr;
        addr = ha;
        mask = m;
        @(posedge clock_i);
        #1;
        req_i = 1'b0;
        s = size_of(wr, m);
        quad = s == SZ_LONG && ha[6:5] == 2'h3;
        case ({s, ha[6:5]})
            4'h0: be = BE_B0;  4'h1: be = BE_B1;
            4'h2: be = BE_B2;  4'h3: be = BE_B3;
            4'h4: be = BE_W0;  4'h5: be = BE_W1;
            4'h6: be = BE_W2;  4'h8: be = BE_T0;
            4'h9: be = BE_T1;  default: be = BE_ALL;
        endcase
        io = ha[33:29] == RGN_IO;
        cf = ha[33:29] == RGN_CFG;
        ia = ha[33:28] == RGN_IACK;
        cs = ha[33:28] == RGN_CSR;
        ad = {XTN_ZERO, ha[28:8], ha[7], ha[6:5]};
        if (quad) ad[2:0] = 3'h0;
        if (ha[28:23] != 6'h00) ad[31:24] = ext;
        cmd = wr ? CMD_IOWR : CMD_IORD;
        if (ia)
        begin
            cmd = wr ? CMD_SPEC : CMD_IACK;
            ad = AD_ZERO;
            if (wr) be = BE_ALL;
        end
        if (cf)
        begin
            cmd = wr ? CMD_CFGWR : CMD_CFGRD;
            ad = {21'h0, ha[15:13], ha[12:7], ext[1:0]};
            if (ext[1:0] != BUS_PRI) ad[23:11] = ha[28:16];
            else if (ha[20:16] < DEV_LIMIT) ad[11+ha[20:16]] = 1'b1;
        end
        chk({pci_req, csr_claim, miss}, {io|ia|cf, cs, !(io|ia|cf|cs)},
            "strobes");
        if (io | ia | cf)
        begin
            chk(pci_cmd, cmd, "cmd");
            chk(pci_ad, ad, "ad");
            chk(pci_be_n, be, "be");
            if (!(ia && wr)) chk(pci_phases, quad ? 2 : 1, "phases");
        end
    endtask

    task complete_run;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        errors++;
        $display("ERROR %0t watchdog expired", $time);
        complete_run;
    end

    initial
    begin
        void'($urandom(17));
        repeat (5) @(posedge clock_i);
        #1;
        srst_i = 1'b0;
        chk_reset;
        for (int c = 0; c < 32; c++)
        begin
            a = {RGN_IO, 29'h0};
            a[7:5] = {c[4], c[1:0]};
            access(a, c[4], c[4] ? 8'(1 << (2 * c[3:2])) : 8'(c[3:2]));
        end
        for (int k = 0; k < 32; k++)
        begin
            access({RGN_CFG, 8'h5a, k[4:0], 16'h2b80}, 1'b0, 8'h03);
            chk(acc, k == 3, "target accept");
        end
        ext = 8'h01;
        for (int b = 4; b < 9; b++)
        begin
            access({RGN_CFG, b[7:0], 5'h02, 16'h1234}, 1'b1, 8'h40);
            chk({reiss, fwd}, {b == 5, b > 5 && b < 8}, "bridge");
        end
        // longword iack store and read, io store, then reset with a request pending
        access({RGN_IACK, 28'h000_0000}, 1'b1, 8'h40);
        access({RGN_IACK, 28'h000_0000}, 1'b0, 8'h03);
        access({RGN_IO, 29'h080_0100}, 1'b1, 8'h40);
        @(posedge clock_i);
        #1;
        srst_i = 1'b1;
        req_i = 1'b1;
        @(posedge clock_i);
        #1;
        srst_i = 1'b0;
        req_i = 1'b0;
        chk_reset;
        repeat (600)
        begin
            a = {2'h0, 32'($urandom)};
            case ($urandom_range(0, 4))
                0: a[33:28] = RGN_CSR;
                1: a[33:28] = RGN_IACK;
                2: a[33:29] = RGN_IO;
                3: a[33:29] = RGN_CFG;
                default: a[33:28] = 6'h30;
            endcase
            if ($urandom_range(0, 3) == 0) a[28:23] = 6'h00;
            ext = 8'($urandom);
            access(a, 1'($urandom), 8'($urandom));
        end
        complete_run;
    end
endmodule // host_to_pci_io_config_decode_tb_top
